// ---- rtl/spms_map.vh ----
/*
 * Register map and field positions of the serial port.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
`ifndef SPMS_MAP_VH
`define SPMS_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPMS_CONTROL_OFS 8'h00
`define SPMS_STATUS_OFS 8'h04
`define SPMS_DATA_OFS 8'h08

// ----------------------------------------
// control_reg fields
// ----------------------------------------
`define SPMS_CTL_RATE2 7
`define SPMS_CTL_ENABLE 6
`define SPMS_CTL_SSIGN 5
`define SPMS_CTL_MASTER 4
`define SPMS_CTL_CLOCK_IDLE_LEVEL 3
`define SPMS_CTL_CLOCK_SAMPLE_PHASE 2
`define SPMS_CTL_RATE1 1
`define SPMS_CTL_RATE0 0
`define SPMS_CTL_RESET 8'h14

// ----------------------------------------
// status_control_reg fields
// ----------------------------------------
`define SPMS_ST_DONE 7
`define SPMS_ST_OVR 5
`define SPMS_ST_MODE_FAULT_FLAG 4
`define SPMS_ST_TXE 3
`define SPMS_ST_TXEIE 1

// ----------------------------------------
// Serial framing
// ----------------------------------------
`define SPMS_LAST_EDGE 4'hF
`define SPMS_BITS 4'h8

`endif

// ---- rtl/spms_top.v ----
/*
 * Full-duplex serial port, master or slave, with APB register access.
 * Assumes one 250 MHz clock; SCK, MOSI, MISO and SS arrive from pins.
 */
`include "spms_map.vh"

// Overview of operation
// - Master write to data window starts transfer, byte loads shift register at once
// - Byte shifts in meanwhile; at end done flag sets and received byte copies out
// - Done flag clears on status read with flag set, then data read
// - Slave with phase clear moves complete received byte at once and sets done flag
// - Late slave write leaves previous shift register content to transmit
// - Idle level and sample phase select four clock formats
// - Phase clear samples on leaving idle; set samples on returning idle
// - Phase clear: MSB before first edge, SS fall starts each transfer
// - Phase set: first SCK edge starts transfer, SS may stay low
// - Queued byte follows the current one with no gap
// - Tx empty flag set while buffer free, cleared by data write
// - Slave with nothing queued sends the last byte received
// - Master mode fault sets flag, requests interrupt, clears enable and master
// - Mode fault clears on status read then control write; that same write may set enable again
// - SS ignore: no master mode fault; master unselected, slave selected with phase set
// - Slave sets mode fault when SS rises after selection
// - Slave transfer starts on SS fall, ends when SCK returns idle
// - Slave SS high: MISO released, counter cleared, SCK ignored
// - Byte arriving while previous unread sets overrun and is dropped
// - Done flag requests only with tx irq enable clear; mode fault only with SS ignore clear
// - Tx empty flag requests only with tx irq enable set
// - Master SCK is clock divided by 4 to 128; codes 000, 111 invalid
// - SS ignore suppresses mode fault requests; slave ignores it with phase clear
module spms_top (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sck_i,
    output reg sck_o,
    output reg sck_oe,
    input wire mosi_i,
    output reg mosi_o,
    output reg mosi_oe,
    input wire miso_i,
    output reg miso_o,
    output reg miso_oe,
    input wire ss_n_i,
    output reg xfer_irq,
    output reg tx_irq,
    output reg mode_fault_flag_irq
);

// ----------------------------------------
// Rate decode
// ----------------------------------------
function [6:0] half_period;
    input [2:0] code;
    begin
        case (code)
            3'h1: half_period = 7'h02;
            3'h2: half_period = 7'h04;
            3'h3: half_period = 7'h08;
            3'h4: half_period = 7'h10;
            3'h5: half_period = 7'h20;
            3'h6: half_period = 7'h40;
            default: half_period = 7'h00;
        endcase
    end
endfunction

// ----------------------------------------
// State
// ----------------------------------------
reg [7:0] ctl;
reg done;
reg overrun_flag;
reg mode_fault_flag;
reg txeie;
reg tx_full;
reg [7:0] tx_data;
reg [7:0] rx_data;
reg [7:0] sr;
reg in_bit;
reg out_q;
reg busy;
reg [3:0] edge_cnt;
reg [3:0] bit_cnt;
reg [6:0] div_cnt;
reg done_armed;
reg mode_fault_flag_armed;
reg [2:0] sck_s;
reg [2:0] ss_s;
reg [2:0] mosi_s;
reg [2:0] miso_s;
reg sck_f;
reg ss_f;
reg mosi_f;
reg miso_f;
reg sel_q;

wire en = ctl[`SPMS_CTL_ENABLE];
wire mst = ctl[`SPMS_CTL_MASTER];
wire clock_idle_level = ctl[`SPMS_CTL_CLOCK_IDLE_LEVEL];
wire clock_sample_phase = ctl[`SPMS_CTL_CLOCK_SAMPLE_PHASE];
wire ssign = ctl[`SPMS_CTL_SSIGN];
wire [2:0] rate = {ctl[`SPMS_CTL_RATE2], ctl[`SPMS_CTL_RATE1], ctl[`SPMS_CTL_RATE0]};
wire [6:0] half = half_period(rate);
wire rate_ok = (half != 7'h00);

// ----------------------------------------
// APB decode
// ----------------------------------------
wire setup = psel && !penable;
wire acc = psel && penable && pready;
wire wr_ctl = acc && pwrite && (paddr == `SPMS_CONTROL_OFS);
wire wr_st = acc && pwrite && (paddr == `SPMS_STATUS_OFS);
wire wr_dat = acc && pwrite && (paddr == `SPMS_DATA_OFS);
wire rd_st = acc && !pwrite && (paddr == `SPMS_STATUS_OFS);
wire rd_dat = acc && !pwrite && (paddr == `SPMS_DATA_OFS);
wire mapped = (paddr == `SPMS_CONTROL_OFS) || (paddr == `SPMS_STATUS_OFS)
    || (paddr == `SPMS_DATA_OFS);

reg [7:0] st_view;
always @*
begin
    st_view = 8'h00;
    st_view[`SPMS_ST_DONE] = done;
    st_view[`SPMS_ST_OVR] = overrun_flag;
    st_view[`SPMS_ST_MODE_FAULT_FLAG] = mode_fault_flag;
    st_view[`SPMS_ST_TXE] = !tx_full;
    st_view[`SPMS_ST_TXEIE] = txeie;
end

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
always @(posedge clk)
begin
    if (srst)
    begin
        sck_s <= 3'h0;
        ss_s <= 3'h7;
        mosi_s <= 3'h0;
        miso_s <= 3'h0;
        sck_f <= 1'b0;
        ss_f <= 1'b1;
        mosi_f <= 1'b0;
        miso_f <= 1'b0;
    end
    else
    begin
        sck_s <= {sck_s[1:0], sck_i};
        ss_s <= {ss_s[1:0], ss_n_i};
        mosi_s <= {mosi_s[1:0], mosi_i};
        miso_s <= {miso_s[1:0], miso_i};
        if (sck_s[1] == sck_s[2])
            sck_f <= sck_s[2];
        if (ss_s[1] == ss_s[2])
            ss_f <= ss_s[2];
        if (mosi_s[1] == mosi_s[2])
            mosi_f <= mosi_s[2];
        if (miso_s[1] == miso_s[2])
            miso_f <= miso_s[2];
    end
end

// ----------------------------------------
// Slave edge events
// ----------------------------------------
wire sck_new = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
wire ss_new = (ss_s[1] == ss_s[2]) ? ss_s[2] : ss_f;
wire slv_ssign = ssign && clock_sample_phase;
wire slv_sel = en && !mst && (slv_ssign || !ss_f);
wire sck_edge = slv_sel && (sck_new != sck_f);
wire s_lead = sck_edge && (sck_new != clock_idle_level);
wire s_trail = sck_edge && (sck_new == clock_idle_level);
wire s_sample = clock_sample_phase ? s_trail : s_lead;
wire s_drive = clock_sample_phase ? s_lead : s_trail;
wire s_end = s_trail && (bit_cnt == `SPMS_BITS);
wire ss_fall = en && !mst && !slv_ssign && ss_f && !ss_new;
wire ss_rise = en && !mst && !slv_ssign && !ss_f && ss_new;

// ----------------------------------------
// Master clock events
// ----------------------------------------
wire tick = busy && mst && (div_cnt == 7'h01);
wire m_lead = tick && !edge_cnt[0];
wire m_trail = tick && edge_cnt[0];
wire m_sample = clock_sample_phase ? m_trail : m_lead;
wire m_drive = clock_sample_phase ? m_lead : m_trail;
wire m_end = m_trail && (edge_cnt == `SPMS_LAST_EDGE);
wire m_start = en && mst && rate_ok && !busy && tx_full;
wire m_fault = en && mst && !ssign && !ss_f;

wire xfer_end = m_end || s_end;
wire sample = m_sample || s_sample;
wire drive = m_drive || s_drive;
wire [7:0] rx_next = {sr[6:0], in_bit};
wire in_now = mst ? miso_f : mosi_f;
wire [7:0] xfer_byte = {sr[6:0], clock_sample_phase ? in_now : in_bit};

// ----------------------------------------
// Shift engine
// ----------------------------------------
always @(posedge clk)
begin
    if (srst || !en)
    begin
        sr <= 8'h00;
        in_bit <= 1'b0;
        out_q <= 1'b0;
        busy <= 1'b0;
        edge_cnt <= 4'h0;
        bit_cnt <= 4'h0;
        div_cnt <= 7'h00;
        sck_o <= clock_idle_level;
    end
    else
    begin
        if (!mst && !slv_sel)
            bit_cnt <= 4'h0;
        if (sample)
        begin
            in_bit <= mst ? miso_f : mosi_f;
            bit_cnt <= bit_cnt + 4'h1;
        end
        if (drive)
            out_q <= clock_sample_phase ? sr[7] : sr[6];
        if (sample && clock_sample_phase)
            sr <= {sr[6:0], mst ? miso_f : mosi_f};
        else if (drive && !clock_sample_phase)
            sr <= rx_next;
        if (m_start)
        begin
            sr <= tx_data;
            out_q <= tx_data[7];
            busy <= 1'b1;
            edge_cnt <= 4'h0;
            div_cnt <= half;
        end
        else if (tick)
        begin
            sck_o <= !sck_o;
            edge_cnt <= edge_cnt + 4'h1;
            div_cnt <= half;
            if (m_end && tx_full)
            begin
                sr <= tx_data;
                out_q <= tx_data[7];
            end
            else if (m_end)
                busy <= 1'b0;
        end
        else if (busy && mst)
            div_cnt <= div_cnt - 7'h01;
        if (!busy && mst)
            sck_o <= clock_idle_level;
        if (s_end)
        begin
            bit_cnt <= 4'h0;
            if (tx_full)
            begin
                sr <= tx_data;
                out_q <= tx_data[7];
            end
            else
            begin
                sr <= xfer_byte;
                out_q <= xfer_byte[7];
            end
        end
        if (ss_fall)
        begin
            bit_cnt <= 4'h0;
            if (tx_full)
            begin
                sr <= tx_data;
                out_q <= tx_data[7];
            end
            else
                out_q <= sr[7];
        end
    end
end

// ----------------------------------------
// Registers and flags
// ----------------------------------------
wire tx_take = m_start || (m_end && tx_full) || ((s_end || ss_fall) && tx_full);

always @(posedge clk)
begin
    if (srst)
    begin
        ctl <= `SPMS_CTL_RESET;
        done <= 1'b0;
        overrun_flag <= 1'b0;
        mode_fault_flag <= 1'b0;
        txeie <= 1'b0;
        tx_full <= 1'b0;
        tx_data <= 8'h00;
        rx_data <= 8'h00;
        done_armed <= 1'b0;
        mode_fault_flag_armed <= 1'b0;
        sel_q <= 1'b0;
    end
    else
    begin
        sel_q <= !mst && en && !slv_ssign && !ss_f;
        if (rd_st && prdata[`SPMS_ST_DONE])
            done_armed <= 1'b1;
        if (rd_st && prdata[`SPMS_ST_MODE_FAULT_FLAG])
            mode_fault_flag_armed <= 1'b1;
        if (rd_dat && done_armed)
        begin
            done <= 1'b0;
            overrun_flag <= 1'b0;
            done_armed <= 1'b0;
        end
        if (wr_st)
            txeie <= pwdata[`SPMS_ST_TXEIE];
        if (wr_ctl)
        begin
            ctl <= pwdata[7:0];
            if (mode_fault_flag && !mode_fault_flag_armed)
                ctl[`SPMS_CTL_ENABLE] <= 1'b0;
            if (mode_fault_flag_armed)
            begin
                mode_fault_flag <= 1'b0;
                mode_fault_flag_armed <= 1'b0;
            end
        end
        if (tx_take || !en)
            tx_full <= 1'b0;
        if (wr_dat && en)
        begin
            tx_data <= pwdata[7:0];
            tx_full <= 1'b1;
        end
        if (xfer_end)
        begin
            if (done)
                overrun_flag <= 1'b1;
            else
                rx_data <= xfer_byte;
            done <= 1'b1;
        end
        if (m_fault)
        begin
            mode_fault_flag <= 1'b1;
            ctl[`SPMS_CTL_ENABLE] <= 1'b0;
            ctl[`SPMS_CTL_MASTER] <= 1'b0;
        end
        if (ss_rise && sel_q)
            mode_fault_flag <= 1'b1;
    end
end

// ----------------------------------------
// Bus answer and pin drivers
// ----------------------------------------
always @(posedge clk)
begin
    if (srst)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        sck_oe <= 1'b0;
        mosi_o <= 1'b0;
        mosi_oe <= 1'b0;
        miso_o <= 1'b0;
        miso_oe <= 1'b0;
        xfer_irq <= 1'b0;
        tx_irq <= 1'b0;
        mode_fault_flag_irq <= 1'b0;
    end
    else
    begin
        pready <= setup;
        pslverr <= setup && !mapped;
        if (setup)
        begin
            case (paddr)
                `SPMS_CONTROL_OFS: prdata <= {24'h000000, ctl};
                `SPMS_STATUS_OFS: prdata <= {24'h000000, st_view};
                `SPMS_DATA_OFS: prdata <= {24'h000000, rx_data};
                default: prdata <= 32'h00000000;
            endcase
        end
        sck_oe <= en && mst;
        mosi_oe <= en && mst;
        mosi_o <= out_q;
        miso_o <= out_q;
        miso_oe <= slv_sel;
        xfer_irq <= done && !txeie;
        tx_irq <= !tx_full && txeie;
        mode_fault_flag_irq <= mode_fault_flag && !ssign;
    end
end

endmodule // spms_top

// ---- verif/spms_slave_model.sv ----
/* Behavioural serial slave facing the port in master role.
   Assumes sel_n, format and tx byte are set by the bench between frames. */
module spms_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic clock_idle_level,
    input wire logic clock_sample_phase,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx,
    output int bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    initial
    begin
        miso = 1'b0;
        rx = 8'h00;
        bits = 0;
        sh = 8'h00;
    end
    always @(negedge sel_n)
    begin
        sh = clock_sample_phase ? tx : {tx[6:0], 1'b0};
        if (!clock_sample_phase)
            miso = tx[7];
    end
    always @(posedge sel_n)
        miso = ~miso;
    always @(sck)
        if (!sel_n)
        begin
            if ((sck != clock_idle_level) != clock_sample_phase)
            begin
                rx = {rx[6:0], mosi};
                bits = bits + 1;
                if (clock_sample_phase && bits % 8 == 0)
                    sh = tx;
            end
            else
            begin
                miso = sh[7];
                sh = {sh[6:0], 1'b0};
            end
        end
endmodule // spms_slave_model

// ---- verif/spms_top_asserts.sv ----
/* Port checker for spms_top.
   Assumes a bind to spms_top; control bits are shadowed from APB writes. */
`include "spms_map.vh"
module spms_top_asserts (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sck_i,
    input wire sck_o,
    input wire sck_oe,
    input wire mosi_i,
    input wire mosi_o,
    input wire mosi_oe,
    input wire miso_i,
    input wire miso_o,
    input wire miso_oe,
    input wire ss_n_i,
    input wire xfer_irq,
    input wire tx_irq,
    input wire mode_fault_flag_irq
);
    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    reg [7:0] ctl;
    reg [3:0] tog;
    always @(posedge clk)
    begin
        if (srst)
            ctl <= `SPMS_CTL_RESET;
        else if (psel && penable && pready && pwrite && !pslverr && paddr == `SPMS_CONTROL_OFS)
            ctl <= pwdata[7:0];
        if (srst || !sck_oe)
            tog <= 4'h0;
        else
            tog <= tog + {3'h0, $changed(sck_o)};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_master_sel_low;
        (sck_oe && !ss_n_i && !ctl[`SPMS_CTL_SSIGN])[*4];
    endsequence
    property p_apb_ready; psel && !penable |=> pready; endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_irq_excl; !(xfer_irq && tx_irq); endproperty
    a_irq_excl: assert property (p_irq_excl) else $error("both irqs high");
    property p_mode_fault_flag_stop; $rose(mode_fault_flag_irq) |-> ##[0:2] !sck_oe; endproperty
    a_mode_fault_flag_stop: assert property (p_mode_fault_flag_stop) else $error("master kept driving");
    property p_mode_fault_flag_master; s_master_sel_low |-> ##[1:6] mode_fault_flag_irq; endproperty
    a_mode_fault_flag_master: assert property (p_mode_fault_flag_master) else $error("no mode fault");
    property p_release; (ss_n_i && !ctl[`SPMS_CTL_SSIGN])[*6] |-> !miso_oe; endproperty
    a_release: assert property (p_release) else $error("miso driven unselected");
    property p_oe_pair; mosi_oe == sck_oe && !(miso_oe && sck_oe); endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("enable mix");
    property p_half; sck_oe && $changed(sck_o) |=> $stable(sck_o); endproperty
    a_half: assert property (p_half) else $error("half period short");
    property p_bad_rate;
        sck_oe && ctl[7] == ctl[1] && ctl[1] == ctl[0] |=> $stable(sck_o);
    endproperty
    a_bad_rate: assert property (p_bad_rate) else $error("invalid rate clocks");
    property p_eight; $rose(xfer_irq) |-> tog[3:1] == 3'h0; endproperty
    a_eight: assert property (p_eight) else $error("pulse count off");
endmodule // spms_top_asserts

bind spms_top spms_top_asserts chk_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_n_i), .xfer_irq(xfer_irq), .tx_irq(tx_irq), .mode_fault_flag_irq(mode_fault_flag_irq));

// ---- verif/spms_top_bench.sv ----
/* Self-checking bench for spms_top in master and slave roles.
   Assumes the slave model and the bound checker. */
`include "spms_map.vh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module spms_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, er;
    logic xfer_irq, tx_irq, mode_fault_flag_irq, miso_i, ss_n_i = 1'b1, sel_n = 1'b1;
    logic clock_idle_level = 1'b0, clock_sample_phase = 1'b0, sck_i = 1'b0, mosi_i = 1'b0;
    logic [7:0] t, m;
    logic [7:0] stx = 8'h00, srx, b1, b2, e;
    int sbits, s0, c, err_total = 0, checks = 0;
    logic [7:0] q[$];
    always #2 clk = ~clk;
    spms_top dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
        .ss_n_i(ss_n_i), .xfer_irq(xfer_irq), .tx_irq(tx_irq), .mode_fault_flag_irq(mode_fault_flag_irq));
    spms_slave_model slv_u (.sck(sck_o), .mosi(mosi_o), .sel_n(sel_n), .clock_idle_level(clock_idle_level),
        .clock_sample_phase(clock_sample_phase), .tx(stx), .miso(miso_i), .rx(srx), .bits(sbits));
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge clk);
            penable <= 1'b1;
            @(negedge clk);
            while (pready !== 1'b1 && n < 20)
            begin
                n++;
                @(posedge clk);
                @(negedge clk);
            end
            if (n >= 20)
                err_total++;
            rd = prdata;
            er = pslverr;
            @(posedge clk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic xfer(input logic pl, input logic ph);
        int n;
        begin
            n = 0;
            apb(1, `SPMS_CONTROL_OFS, {4'h1, pl, ph, 2'h3});
            apb(1, `SPMS_CONTROL_OFS, {4'h5, pl, ph, 2'h3});
            clock_idle_level = pl;
            clock_sample_phase = ph;
            stx = $urandom;
            q.push_back(stx);
            b1 = $urandom;
            sel_n <= 1'b0;
            @(posedge clk);
            apb(1, `SPMS_DATA_OFS, b1);
            do apb(0, `SPMS_STATUS_OFS, 0); while (rd[`SPMS_ST_DONE] !== 1'b1 && ++n < 200);
            apb(0, `SPMS_DATA_OFS, 0);
            e = q.pop_front();
            `CHK("rx byte", e, rd[7:0])
            `CHK("slave rx", b1, srx)
            sel_n <= 1'b1;
            @(posedge clk);
        end
    endtask
    task automatic test_done();
        begin
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        err_total++;
        test_done();
    end
    initial
    begin
        void'($urandom(32'hE2FAA692));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb(0, `SPMS_CONTROL_OFS, 0);
        `CHK("ctl reset", 8'h14, rd[7:0])
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("status reset", 8'h08, rd[7:0])
        apb(0, 8'h0C, 0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        apb(1, `SPMS_STATUS_OFS, 8'h02);
        repeat (2) @(negedge clk);
        `CHK("tx irq", 2'b10, {tx_irq, xfer_irq})
        apb(1, `SPMS_STATUS_OFS, 8'h00);
        $display("test registers done");
        for (int f = 0; f < 4; f++)
            xfer(f[1], f[0]);
        $display("test formats done");
        b1 = $urandom;
        b2 = $urandom;
        e = $urandom;
        stx = e;
        sel_n <= 1'b0;
        @(posedge clk);
        s0 = sbits;
        apb(1, `SPMS_DATA_OFS, b1);
        stx = $urandom;
        apb(1, `SPMS_DATA_OFS, b2);
        c = 0;
        while (sbits < s0 + 1 && c < 500) @(posedge clk) c++;
        c = 0;
        while (sbits < s0 + 16 && c < 500) @(posedge clk) c++;
        `CHK("no gap", 1'b1, c >= 239 && c <= 241)
        repeat (40) @(posedge clk);
        `CHK("slave rx 2", b2, srx)
        `CHK("xfer irq", 2'b01, {tx_irq, xfer_irq})
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("overrun", 8'hA8, rd[7:0])
        apb(0, `SPMS_DATA_OFS, 0);
        `CHK("kept byte", e, rd[7:0])
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("cleared", 8'h08, rd[7:0])
        sel_n <= 1'b1;
        $display("test queue done");
        apb(1, `SPMS_CONTROL_OFS, 8'h57);
        ss_n_i <= 1'b0;
        repeat (12) @(posedge clk);
        `CHK("mode_fault_flag irq", 1'b1, mode_fault_flag_irq)
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("mode_fault_flag set", 8'h18, rd[7:0])
        apb(0, `SPMS_CONTROL_OFS, 0);
        `CHK("ctl after fault", 8'h07, rd[7:0])
        ss_n_i <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1, `SPMS_CONTROL_OFS, 8'h57);
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("mode_fault_flag clear", 8'h08, rd[7:0])
        $display("test fault done");
        apb(1, `SPMS_CONTROL_OFS, 8'h54);
        apb(1, `SPMS_DATA_OFS, b1);
        repeat (300) @(posedge clk);
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("bad rate", 8'h00, rd[7:0])
        apb(1, `SPMS_CONTROL_OFS, 8'h14);
        $display("test rate done");
        t = $urandom;
        m = $urandom;
        apb(1, `SPMS_CONTROL_OFS, 8'h40);
        apb(1, `SPMS_DATA_OFS, t);
        @(posedge clk);
        ss_n_i <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_i <= m[i];
            repeat (12) @(posedge clk);
            b2 = {b2[6:0], miso_o};
            sck_i <= 1'b1;
            repeat (12) @(posedge clk);
            sck_i <= 1'b0;
        end
        repeat (12) @(posedge clk);
        `CHK("slave tx", t, b2)
        `CHK("miso oe", 1'b1, miso_oe)
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("slave done", 8'h88, rd[7:0])
        apb(0, `SPMS_DATA_OFS, 0);
        `CHK("port rx", m, rd[7:0])
        ss_n_i <= 1'b1;
        repeat (12) @(posedge clk);
        `CHK("slave mode_fault_flag", 2'b10, {mode_fault_flag_irq, miso_oe})
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("slave mode_fault_flag set", 8'h18, rd[7:0])
        apb(1, `SPMS_CONTROL_OFS, 8'h14);
        apb(0, `SPMS_STATUS_OFS, 0);
        `CHK("slave mode_fault_flag clear", 8'h08, rd[7:0])
        $display("test slave done");
        test_done();
    end
endmodule // spms_top_bench
